/* common/clk_sel_pkg.sv */
// Constants, field layout and decode helpers for the clock source select block.
// Assumes a single 40 MHz core clock and a software register port.
package clk_sel_pkg;

    // Register indices on the plain register port
    localparam int          REG_ADDR_W         = 4;
    localparam int          REG_DATA_W         = 16;
    localparam logic [3:0]  SYS_CLK_CTRL3_IDX  = 4'h0;
    localparam logic [3:0]  MAIN_WAIT_CTRL_IDX = 4'h1;
    localparam logic [3:0]  PLL_CTRL_IDX       = 4'h2;
    localparam logic [3:0]  PLL_CTRL_TWO_IDX   = 4'h3;
    localparam logic [3:0]  MAIN_OSC_CTRL_IDX  = 4'h4;
    localparam logic [3:0]  OSC_STABLE_IDX     = 4'h5;

    // Field positions
    localparam int SRC_SEL_LSB  = 8;
    localparam int SRC_SEL_MSB  = 10;
    localparam int WAIT_LSB     = 0;
    localparam int WAIT_MSB     = 4;
    localparam int PLL_DIV_LSB  = 0;
    localparam int PLL_DIV_MSB  = 1;
    localparam int PLL_MUL_LSB  = 8;
    localparam int PLL_MUL_MSB  = 11;
    localparam int RUN_BIT      = 0;
    localparam int MAIN_STB_BIT = 0;
    localparam int PLL_STB_BIT  = 1;

    typedef enum logic [2:0] {
        SRC_SLOW = 3'h0,
        SRC_FAST = 3'h1,
        SRC_MAIN = 3'h2,
        SRC_SUB  = 3'h3,
        SRC_PLL  = 3'h4
    } clk_src_t;

    // Reset values
    localparam logic [2:0] SRC_SEL_RST  = 3'h0;
    localparam logic [4:0] WAIT_RST     = 5'h00;
    localparam logic [1:0] PLL_DIV_RST  = 2'h0;
    localparam logic [3:0] PLL_MUL_RST  = 4'h0;
    localparam logic       RUN_RST      = 1'b0;

    // PLL ratio: multiplier code n gives 4 + n/2, reported doubled
    localparam logic [3:0] PLL_MUL_MAX  = 4'h8;
    localparam logic [4:0] PLL_MUL_BASE = 5'h08;
    localparam logic [1:0] PLL_DIV_MAX  = 2'h2;

    // Timing: slow internal oscillator cycle seen in core cycles
    localparam real CORE_CLK_MHZ      = 40.0;
    localparam real SLOW_OSC_PERIOD_US = 0.25;
    localparam int  SLOW_TICK_CYCLES   = (SLOW_OSC_PERIOD_US * CORE_CLK_MHZ < 1.0) ? 1 :
                                         int'($floor(SLOW_OSC_PERIOD_US * CORE_CLK_MHZ));
    localparam int  WAIT_W             = 20;

    function automatic logic wait_code_ok(input logic newer, input logic [4:0] code);
        return newer ? (code <= 5'h07) : (code <= 5'h0f);
    endfunction

    function automatic logic [WAIT_W-1:0] wait_ticks(input logic newer, input logic [4:0] code);
        logic [WAIT_W-1:0] n;
        n = 20'h00002;
        if (newer) begin
            if (code != 5'h00 && code <= 5'h07)
                n = 20'h00200 << code[2:0];
        end else begin
            case (code)
                5'h00:   n = 20'h00002;
                5'h01:   n = 20'h00004;
                5'h02:   n = 20'h00008;
                5'h03:   n = 20'h00010;
                5'h04:   n = 20'h00020;
                5'h05:   n = 20'h00100;
                5'h06:   n = 20'h00200;
                5'h07:   n = 20'h00400;
                5'h08:   n = 20'h00800;
                5'h09:   n = 20'h01000;
                5'h0a:   n = 20'h04000;
                5'h0b:   n = 20'h08000;
                5'h0c:   n = 20'h10000;
                5'h0d:   n = 20'h20000;
                5'h0e:   n = 20'h40000;
                5'h0f:   n = 20'h80000;
                default: n = 20'h00002;
            endcase
        end
        return n;
    endfunction

    function automatic logic src_code_ok(input logic has_pll, input logic [2:0] code);
        return (code <= 3'h3) || (has_pll && code == 3'h4);
    endfunction

endpackage

/* hw/osc_wait_counter.sv */
// Main oscillator stabilization wait counter.
// Assumes tick is a one-cycle pulse per slow internal oscillator cycle.
`timescale 1ns/1ps
module osc_wait_counter #(
    parameter int WAIT_W = 20
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Control
    input  wire logic              start,
    input  wire logic              tick,
    input  wire logic [WAIT_W-1:0] target,
    // Status
    output logic                   stable
);
    typedef enum logic [1:0] {
        W_IDLE  = 2'b00,
        W_COUNT = 2'b01,
        W_DONE  = 2'b11
    } wait_state_t;

    wait_state_t       state_r;
    logic [WAIT_W-1:0] count_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= W_IDLE;
            count_r <= '0;
        end else if (!start) begin
            state_r <= W_IDLE;
            count_r <= '0;
        end else begin
            case (state_r)
                W_IDLE: begin
                    state_r <= W_COUNT;
                    count_r <= '0;
                end
                W_COUNT: begin
                    if (tick) begin
                        count_r <= count_r + 1'b1;
                        if (count_r + 1'b1 >= target)
                            state_r <= W_DONE;
                    end
                end
                W_DONE:  state_r <= W_DONE;
                default: state_r <= W_IDLE;
            endcase
        end
    end

    assign stable = (state_r == W_DONE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    flag_after_count_a: assert property (
        $rose(stable) |-> $past(count_r) + 1'b1 >= $past(target) && $past(tick))
        else $error("stable raised before count reached target");
    flag_drops_stop_a: assert property (!start |=> !stable)
        else $error("stable held after oscillator stopped");
endmodule

/* hw/clock_source_select_wait.sv */
// Clock source selection, oscillator wait and PLL ratio registers.
// Assumes software on a plain register port and synchronous inputs.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - Bits 10:8 pick slow, fast, main, sub source
// - PLL variant: code 100 selects PLL output
// - Older variant: sixteen wait codes, 2 to 524288
// - Newer variant: code 0 is 2, then 1024..65536
// - Newer variant counts slow oscillator cycles, 0.25us
// - PLL multiplier 4 to 8 in half steps
// - PLL input main clock divided 1, 2, 4
module clock_source_select_wait #(
    parameter bit HAS_PLL    = 1'b1,
    parameter int WAIT_SHIFT = 0
) (
    // Clock and reset
    input  wire logic                                  CORE_CLK,
    input  wire logic                                  RESET,
    // Register port
    input  wire logic [clk_sel_pkg::REG_ADDR_W-1:0]    REG_ADDR,
    input  wire logic [clk_sel_pkg::REG_DATA_W-1:0]    REG_WDATA,
    input  wire logic                                  REG_WR,
    input  wire logic                                  REG_RD,
    output logic      [clk_sel_pkg::REG_DATA_W-1:0]    REG_RDATA,
    // Clock tree controls
    output logic      [4:0]                            CLK_SRC_SEL,
    output logic                                       MAIN_OSC_EN,
    output logic                                       MAIN_OSC_STABLE,
    output logic                                       PLL_EN,
    output logic      [2:0]                            PLL_IN_DIV,
    output logic      [4:0]                            PLL_MUL_X2
);
    localparam int TICK_W = $clog2(clk_sel_pkg::SLOW_TICK_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(clk_sel_pkg::SLOW_TICK_CYCLES - 1);

    logic [2:0]  src_sel_r;
    logic [4:0]  wait_code_r;
    logic [1:0]  pll_div_r;
    logic [3:0]  pll_mul_r;
    logic        pll_run_r;
    logic        main_run_r;
    logic [TICK_W-1:0] tick_cnt_r;
    logic        slow_tick;
    logic        main_stable;
    logic [clk_sel_pkg::WAIT_W-1:0] wait_target;
    logic [clk_sel_pkg::WAIT_W-1:0] wait_full;
    logic [clk_sel_pkg::REG_DATA_W-1:0] rdata_nxt;

    function automatic logic is_wr(input logic [3:0] a, input logic [3:0] idx);
        return REG_WR && (a == idx);
    endfunction

    // Source select; an illegal code keeps the previous source
    always_ff @(posedge CORE_CLK) begin
        if (RESET)
            src_sel_r <= clk_sel_pkg::SRC_SEL_RST;
        else if (is_wr(REG_ADDR, clk_sel_pkg::SYS_CLK_CTRL3_IDX) &&
                 clk_sel_pkg::src_code_ok(HAS_PLL,
                     REG_WDATA[clk_sel_pkg::SRC_SEL_MSB:clk_sel_pkg::SRC_SEL_LSB]))
            src_sel_r <= REG_WDATA[clk_sel_pkg::SRC_SEL_MSB:clk_sel_pkg::SRC_SEL_LSB];
    end

    // Wait code; unlisted codes are refused rather than left undefined
    always_ff @(posedge CORE_CLK) begin
        if (RESET)
            wait_code_r <= clk_sel_pkg::WAIT_RST;
        else if (is_wr(REG_ADDR, clk_sel_pkg::MAIN_WAIT_CTRL_IDX) &&
                 clk_sel_pkg::wait_code_ok(HAS_PLL,
                     REG_WDATA[clk_sel_pkg::WAIT_MSB:clk_sel_pkg::WAIT_LSB]))
            wait_code_r <= REG_WDATA[clk_sel_pkg::WAIT_MSB:clk_sel_pkg::WAIT_LSB];
    end

    // PLL ratios
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            pll_div_r <= clk_sel_pkg::PLL_DIV_RST;
            pll_mul_r <= clk_sel_pkg::PLL_MUL_RST;
        end else if (HAS_PLL && is_wr(REG_ADDR, clk_sel_pkg::PLL_CTRL_IDX)) begin
            if (REG_WDATA[clk_sel_pkg::PLL_DIV_MSB:clk_sel_pkg::PLL_DIV_LSB]
                    <= clk_sel_pkg::PLL_DIV_MAX)
                pll_div_r <= REG_WDATA[clk_sel_pkg::PLL_DIV_MSB:clk_sel_pkg::PLL_DIV_LSB];
            if (REG_WDATA[clk_sel_pkg::PLL_MUL_MSB:clk_sel_pkg::PLL_MUL_LSB]
                    <= clk_sel_pkg::PLL_MUL_MAX)
                pll_mul_r <= REG_WDATA[clk_sel_pkg::PLL_MUL_MSB:clk_sel_pkg::PLL_MUL_LSB];
        end
    end

    // Run bits for PLL and main oscillator
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            pll_run_r  <= clk_sel_pkg::RUN_RST;
            main_run_r <= clk_sel_pkg::RUN_RST;
        end else begin
            if (HAS_PLL && is_wr(REG_ADDR, clk_sel_pkg::PLL_CTRL_TWO_IDX))
                pll_run_r <= REG_WDATA[clk_sel_pkg::RUN_BIT];
            if (is_wr(REG_ADDR, clk_sel_pkg::MAIN_OSC_CTRL_IDX))
                main_run_r <= REG_WDATA[clk_sel_pkg::RUN_BIT];
        end
    end

    // Slow internal oscillator cycle marker
    always_ff @(posedge CORE_CLK) begin
        if (RESET)
            tick_cnt_r <= '0;
        else if (tick_cnt_r == TICK_LAST)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + 1'b1;
    end
    assign slow_tick = (tick_cnt_r == TICK_LAST);

    // Core cycles since the last slow tick; lets the period check avoid long repeats
    logic [3:0] tick_gap_r;
    always_ff @(posedge CORE_CLK) begin
        if (RESET || slow_tick)
            tick_gap_r <= 4'h0;
        else if (tick_gap_r != 4'hf)
            tick_gap_r <= tick_gap_r + 4'h1;
    end

    // WAIT_SHIFT only shortens simulation; the floor of one tick stays
    assign wait_full   = clk_sel_pkg::wait_ticks(HAS_PLL, wait_code_r);
    assign wait_target = ((wait_full >> WAIT_SHIFT) == '0) ?
                         clk_sel_pkg::WAIT_W'(1) : (wait_full >> WAIT_SHIFT);

    osc_wait_counter #(
        .WAIT_W (clk_sel_pkg::WAIT_W)
    ) u_main_wait (
        .clk    (CORE_CLK),
        .reset  (RESET),
        .start  (main_run_r),
        .tick   (slow_tick),
        .target (wait_target),
        .stable (main_stable)
    );

    // Outputs
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            CLK_SRC_SEL     <= 5'h01;
            MAIN_OSC_EN     <= 1'b0;
            MAIN_OSC_STABLE <= 1'b0;
            PLL_EN          <= 1'b0;
            PLL_IN_DIV      <= 3'h1;
            PLL_MUL_X2      <= clk_sel_pkg::PLL_MUL_BASE;
        end else begin
            CLK_SRC_SEL     <= 5'h01 << src_sel_r;
            MAIN_OSC_EN     <= main_run_r;
            MAIN_OSC_STABLE <= main_stable;
            PLL_EN          <= pll_run_r;
            PLL_IN_DIV      <= 3'h1 << pll_div_r;
            PLL_MUL_X2      <= clk_sel_pkg::PLL_MUL_BASE + {1'b0, pll_mul_r};
        end
    end

    // Read path; unmapped addresses read zero
    always_comb begin
        rdata_nxt = '0;
        case (REG_ADDR)
            clk_sel_pkg::SYS_CLK_CTRL3_IDX:
                rdata_nxt[clk_sel_pkg::SRC_SEL_MSB:clk_sel_pkg::SRC_SEL_LSB] = src_sel_r;
            clk_sel_pkg::MAIN_WAIT_CTRL_IDX:
                rdata_nxt[clk_sel_pkg::WAIT_MSB:clk_sel_pkg::WAIT_LSB] = wait_code_r;
            clk_sel_pkg::PLL_CTRL_IDX: begin
                rdata_nxt[clk_sel_pkg::PLL_DIV_MSB:clk_sel_pkg::PLL_DIV_LSB] = pll_div_r;
                rdata_nxt[clk_sel_pkg::PLL_MUL_MSB:clk_sel_pkg::PLL_MUL_LSB] = pll_mul_r;
            end
            clk_sel_pkg::PLL_CTRL_TWO_IDX:
                rdata_nxt[clk_sel_pkg::RUN_BIT] = pll_run_r;
            clk_sel_pkg::MAIN_OSC_CTRL_IDX:
                rdata_nxt[clk_sel_pkg::RUN_BIT] = main_run_r;
            clk_sel_pkg::OSC_STABLE_IDX: begin
                rdata_nxt[clk_sel_pkg::MAIN_STB_BIT] = main_stable;
                rdata_nxt[clk_sel_pkg::PLL_STB_BIT]  = main_stable && pll_run_r;
            end
            default: rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET)
            REG_RDATA <= '0;
        else if (REG_RD)
            REG_RDATA <= rdata_nxt;
        else
            REG_RDATA <= '0;
    end

    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    sequence src_write_s(logic [2:0] c);
        REG_WR && REG_ADDR == clk_sel_pkg::SYS_CLK_CTRL3_IDX &&
        REG_WDATA[clk_sel_pkg::SRC_SEL_MSB:clk_sel_pkg::SRC_SEL_LSB] == c;
    endsequence

    main_select_a: assert property (src_write_s(3'h2) ##2 1'b1 |-> CLK_SRC_SEL == 5'h04)
        else $error("main oscillator not selected after write");
    slow_select_a: assert property (src_write_s(3'h0) |-> ##2 CLK_SRC_SEL == 5'h01)
        else $error("slow oscillator not selected after write");
    pll_select_a: assert property (
        (HAS_PLL == 1'b1) and src_write_s(3'h4) |-> ##2 CLK_SRC_SEL == 5'h10)
        else $error("PLL not selected after write");
    bad_code_held_a: assert property (src_write_s(3'h7) |=> $stable(src_sel_r))
        else $error("illegal source code changed selection");
    mul_range_a: assert property (PLL_MUL_X2 >= 5'h08 && PLL_MUL_X2 <= 5'h10)
        else $error("PLL multiplier out of range");
    div_legal_a: assert property (
        PLL_IN_DIV == 3'h1 || PLL_IN_DIV == 3'h2 || PLL_IN_DIV == 3'h4)
        else $error("PLL input divider illegal");
    tick_period_a: assert property (slow_tick == (tick_gap_r == 4'h9))
        else $error("slow oscillator tick period wrong");
    stable_needs_run_a: assert property (MAIN_OSC_STABLE |-> $past(main_run_r, 2))
        else $error("stable flag without running oscillator");
    wait_zero_a: assert property (
        wait_code_r == 5'h00 |-> wait_full == 20'h00002)
        else $error("wait code zero not two cycles");
    wait_new_a: assert property (
        HAS_PLL && wait_code_r == 5'h07 |-> wait_full == 20'h10000)
        else $error("newer wait code seven not 65536");
    wait_old_a: assert property (
        !HAS_PLL && wait_code_r == 5'h0f |-> wait_full == 20'h80000)
        else $error("older wait code fifteen not 524288");
    read_timing_a: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
        else $error("read data outside read answer cycle");
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the clock source select and oscillator wait block.
// Runs both variants on one bus, the wait target shortened by 12 bits.
`timescale 1ns/1ps
module tb_top;
    localparam int SHIFT = 12;
    logic        CORE_CLK  = 1'b0;
    logic        RESET     = 1'b1;
    logic [3:0]  REG_ADDR  = 4'h0;
    logic [15:0] REG_WDATA = 16'h0000;
    logic        REG_WR    = 1'b0;
    logic        REG_RD    = 1'b0;
    logic [15:0] REG_RDATA;
    logic [4:0]  CLK_SRC_SEL;
    logic        MAIN_OSC_EN;
    logic        MAIN_OSC_STABLE;
    logic        PLL_EN;
    logic [2:0]  PLL_IN_DIV;
    logic [4:0]  PLL_MUL_X2;
    logic [4:0]  CLK_SRC_SEL_OLD;
    logic        PLL_EN_OLD;
    logic [4:0]  PLL_MUL_X2_OLD;
    int          n_errors  = 0;
    int          checks    = 0;
    int          cycles    = 0;
    logic [15:0] exp_q[$];
    logic        rd_pend   = 1'b0;
    logic [31:0] lf        = 32'h287a;

    clock_source_select_wait #(.HAS_PLL(1'b1), .WAIT_SHIFT(SHIFT)) uut (
        .CORE_CLK        (CORE_CLK),
        .RESET           (RESET),
        .REG_ADDR        (REG_ADDR),
        .REG_WDATA       (REG_WDATA),
        .REG_WR          (REG_WR),
        .REG_RD          (REG_RD),
        .REG_RDATA       (REG_RDATA),
        .CLK_SRC_SEL     (CLK_SRC_SEL),
        .MAIN_OSC_EN     (MAIN_OSC_EN),
        .MAIN_OSC_STABLE (MAIN_OSC_STABLE),
        .PLL_EN          (PLL_EN),
        .PLL_IN_DIV      (PLL_IN_DIV),
        .PLL_MUL_X2      (PLL_MUL_X2)
    );

    // Older variant on the same bus; only source select, PLL enable and PLL multiplier are watched
    clock_source_select_wait #(.HAS_PLL(1'b0), .WAIT_SHIFT(SHIFT)) uut_old (
        .CORE_CLK        (CORE_CLK),
        .RESET           (RESET),
        .REG_ADDR        (REG_ADDR),
        .REG_WDATA       (REG_WDATA),
        .REG_WR          (REG_WR),
        .REG_RD          (REG_RD),
        .REG_RDATA       (),
        .CLK_SRC_SEL     (CLK_SRC_SEL_OLD),
        .MAIN_OSC_EN     (),
        .MAIN_OSC_STABLE (),
        .PLL_EN          (PLL_EN_OLD),
        .PLL_IN_DIV      (),
        .PLL_MUL_X2      (PLL_MUL_X2_OLD)
    );

    always #12.5 CORE_CLK = ~CORE_CLK;

    task automatic final_report;
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Slow-oscillator ticks for a wait code, shortened like the design; never below one
    function automatic int ticks(input logic [4:0] c);
        int v;
        v = (c == 5'h00) ? 2 : (512 << c);
        v = v >> SHIFT;
        return (v == 0) ? 1 : v;
    endfunction

    // Strobes drop after the taking edge and one idle edge follows
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        REG_WR    <= 1'b1;
        REG_ADDR  <= a;
        REG_WDATA <= d;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
        @(posedge CORE_CLK);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        REG_RD   <= 1'b1;
        REG_ADDR <= a;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        @(posedge CORE_CLK);
    endtask

    task automatic chk_rst;
        @(negedge CORE_CLK);
        chk("src_sel", 20'h1, CLK_SRC_SEL);
        chk("main_en", 20'h0, MAIN_OSC_EN);
        chk("stable", 20'h0, MAIN_OSC_STABLE);
        chk("pll_en", 20'h0, PLL_EN);
        chk("pll_div", 20'h1, PLL_IN_DIV);
        chk("pll_mul", 20'h8, PLL_MUL_X2);
        @(posedge CORE_CLK);
    endtask

    always @(posedge CORE_CLK) begin
        cycles++;
        rd_pend <= REG_RD;
        if (cycles == 30000) begin
            n_errors++;
            final_report;
        end
    end

    // Read data stand only in the cycle after the strobe
    always @(negedge CORE_CLK) begin
        if (rd_pend) begin
            if (exp_q.size() == 0)
                chk("rdata_note", 20'h1, 20'h0);
            else
                chk("rdata", exp_q.pop_front(), REG_RDATA);
        end else if (REG_RDATA !== 16'h0000) begin
            chk("rdata_idle", 20'h0, REG_RDATA);
        end
    end

    initial begin
        logic [2:0] c;
        logic [2:0] cur;
        logic [1:0] cd;
        logic [3:0] cm;
        logic [4:0] cw;
        int         t;
        int         k;
        cur = 3'h0;
        cd  = 2'h0;
        cm  = 4'h0;
        cw  = 5'h00;
        repeat (2) @(posedge CORE_CLK);
        RESET <= 1'b0;
        @(posedge CORE_CLK);
        chk_rst;
        for (int i = 0; i < 8; i++)
            rd((i < 7) ? i[3:0] : 4'hf, 16'h0000);
        wr(4'h9, 16'hffff);
        rd(4'h9, 16'h0000);
        // Random source codes, illegal ones must leave the selection alone
        repeat (16) begin
            lf = lfsr(lf);
            c  = lf[2:0];
            wr(4'h0, {5'h00, c, 8'h00});
            if (c <= 3'h4)
                cur = c;
            rd(4'h0, {5'h00, cur, 8'h00});
            @(negedge CORE_CLK);
            chk("src_sel", 20'h1 << cur, CLK_SRC_SEL);
            @(posedge CORE_CLK);
        end
        for (int n = 0; n < 10; n++) begin
            wr(4'h2, {4'h0, n[3:0], 6'h00, n[1:0]});
            if (n[1:0] != 2'h3)
                cd = n[1:0];
            if (n <= 8)
                cm = n[3:0];
            rd(4'h2, {4'h0, cm, 6'h00, cd});
            @(negedge CORE_CLK);
            chk("pll_div", 20'h1 << cd, PLL_IN_DIV);
            chk("pll_mul", 20'h8 + cm, PLL_MUL_X2);
            @(posedge CORE_CLK);
        end
        wr(4'h3, 16'h0001);
        @(negedge CORE_CLK);
        chk("pll_en", 20'h1, PLL_EN);
        @(posedge CORE_CLK);
        for (int n = 3; n < 9; n++) begin
            wr(4'h1, {11'h000, n[4:0]});
            if (n <= 7)
                cw = n[4:0];
            t = ticks(cw);
            wr(4'h4, 16'h0001);
            k = 1;
            while (MAIN_OSC_STABLE !== 1'b1 && k < t * 10 + 30) begin
                @(negedge CORE_CLK);
                k++;
            end
            chk("stable_win", 20'h1, (k >= t * 10 - 9) && (k <= t * 10 + 15));
            chk("main_en", 20'h1, MAIN_OSC_EN);
            @(posedge CORE_CLK);
            rd(4'h5, 16'h0003);
            rd(4'h1, {11'h000, cw});
            wr(4'h4, 16'h0000);
            // Flag drops one edge after the counter sees the run bit clear
            @(posedge CORE_CLK);
            @(negedge CORE_CLK);
            chk("stable_off", 20'h0, MAIN_OSC_STABLE);
            chk("main_en", 20'h0, MAIN_OSC_EN);
            @(posedge CORE_CLK);
        end
        // Code 4 and wait code 15 meet different fates in the two variants
        wr(4'h0, 16'h0200);
        wr(4'h0, 16'h0400);
        wr(4'h1, 16'h000f);
        rd(4'h1, {11'h000, cw});
        @(negedge CORE_CLK);
        chk("src_sel", 20'h10, CLK_SRC_SEL);
        chk("old_src_sel", 20'h04, CLK_SRC_SEL_OLD);
        chk("old_pll_en", 20'h0, PLL_EN_OLD);
        chk("old_pll_mul", 20'h8, PLL_MUL_X2_OLD);
        @(posedge CORE_CLK);
        // Second reset in mid-run must restore every output
        wr(4'h0, 16'h0300);
        RESET <= 1'b1;
        repeat (2) @(posedge CORE_CLK);
        chk_rst;
        RESET <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        rd(4'h0, 16'h0000);
        repeat (3) @(posedge CORE_CLK);
        chk("notes_left", 20'h0, 20'(exp_q.size()));
        final_report;
    end
endmodule
